/* src/ucr_pkg.sv */
package ucr_pkg;
  // Link timing
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned BAUD_BPS    = 9600;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned MSG_LEN     = 4;
  localparam int unsigned CNT_W       = 16;

  // Character codes
  localparam logic [7:0] CH_UP_T = 8'h54;
  localparam logic [7:0] CH_LO_T = 8'h74;
  localparam logic [7:0] CH_UP_O = 8'h4F;
  localparam logic [7:0] CH_UP_K = 8'h4B;
  localparam logic [7:0] CH_LO_O = 8'h6F;
  localparam logic [7:0] CH_LO_K = 8'h6B;
  localparam logic [7:0] CH_UP_U = 8'h55;
  localparam logic [7:0] CH_UP_C = 8'h43;
  localparam logic [7:0] CH_UP_P = 8'h50;
  localparam logic [7:0] CH_UP_F = 8'h46;
  localparam logic [7:0] CH_UP_E = 8'h45;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_IDLE = 8'hFF;

  // Response selector
  typedef enum logic [2:0] {
    MSG_OK_UP = 3'h0,
    MSG_OK_LO = 3'h1,
    MSG_UC    = 3'h2,
    MSG_PE    = 3'h3,
    MSG_FE    = 3'h4,
    MSG_OE    = 3'h5
  } ucr_msg_t;

  // Frame state, shared by both directions
  typedef enum logic [4:0] {
    FR_IDLE  = 5'b0_0001,
    FR_START = 5'b0_0010,
    FR_DATA  = 5'b0_0100,
    FR_PAR   = 5'b0_1000,
    FR_STOP  = 5'b1_0000
  } ucr_frame_t;

  typedef struct packed {
    logic rx_done_event;
    logic tx_done_event;
    logic rx_error_event;
  } ucr_event_t;
endpackage

/* src/ucr_responder.sv */
`timescale 1ns/1ns
module ucr_responder import ucr_pkg::*; #(
  parameter int unsigned P_CLK_HZ = CLK_HZ,
  parameter int unsigned P_BAUD   = BAUD_BPS
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Serial link
  input  wire logic       i_serial_rx_line,
  output logic            o_serial_tx_line,
  // Events and status
  output ucr_event_t      o_events,
  output logic            o_busy
);
  localparam int unsigned BIT_CYC  = P_CLK_HZ / P_BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam logic [CNT_W-1:0] BIT_LD  = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(HALF_CYC - 1);
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  localparam logic [1:0] LAST_CH  = 2'(MSG_LEN - 1);

  if (BIT_CYC < 4 || BIT_CYC >= (1 << CNT_W)) begin : g_chk
    $error("Clock to bit rate ratio out of range");
  end

  // Receiver
  ucr_frame_t       rx_st_reg;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [2:0]       rx_bit_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_par_reg;
  logic             rx_fin_reg;
  logic             rx_pe_reg;
  logic             rx_fe_reg;
  logic [7:0]       rx_data_reg;
  wire              rx_line  = i_serial_rx_line;
  wire              rx_tick  = (rx_cnt_reg == '0);
  wire              rx_err   = rx_fe_reg | rx_pe_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_st_reg   <= FR_IDLE;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= '0;
      rx_sh_reg   <= '0;
      rx_par_reg  <= 1'b0;
      rx_fin_reg  <= 1'b0;
      rx_pe_reg   <= 1'b0;
      rx_fe_reg   <= 1'b0;
      rx_data_reg <= '0;
    end else begin
      rx_fin_reg <= 1'b0;
      rx_cnt_reg <= rx_tick ? BIT_LD : rx_cnt_reg - 1'b1;
      case (rx_st_reg)
        FR_IDLE: if (!rx_line) begin
          rx_st_reg  <= FR_START;
          rx_cnt_reg <= HALF_LD;
        end
        FR_START: if (rx_tick) begin
          // Glitch shorter than half a bit is dropped
          rx_st_reg  <= rx_line ? FR_IDLE : FR_DATA;
          rx_bit_reg <= '0;
        end
        FR_DATA: if (rx_tick) begin
          rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 1'b1;
          if (rx_bit_reg == LAST_BIT) rx_st_reg <= FR_PAR;
        end
        FR_PAR: if (rx_tick) begin
          rx_par_reg <= rx_line;
          rx_st_reg  <= FR_STOP;
        end
        FR_STOP: if (rx_tick) begin
          // Finish mid stop bit to resync on the next edge early
          rx_st_reg   <= FR_IDLE;
          rx_fin_reg  <= 1'b1;
          rx_data_reg <= rx_sh_reg;
          rx_pe_reg   <= ^{rx_sh_reg, rx_par_reg};
          rx_fe_reg   <= !rx_line;
        end
        default: rx_st_reg <= FR_IDLE;
      endcase
    end
  end

  // Responder
  logic       active_reg;
  logic       ovr_reg;
  logic       launch_reg;
  ucr_msg_t   msg_reg;
  logic [1:0] idx_reg;
  logic       tx_done;
  ucr_msg_t   rx_msg;
  logic [7:0] tx_char;

  assign rx_msg = rx_fe_reg ? MSG_FE :
                  rx_pe_reg ? MSG_PE :
                  (rx_data_reg == CH_UP_T) ? MSG_OK_UP :
                  (rx_data_reg == CH_LO_T) ? MSG_OK_LO : MSG_UC;

  function automatic logic [7:0] head_char(input ucr_msg_t m, input logic second);
    logic [7:0] c;
    c = CH_IDLE;
    case (m)
      MSG_OK_UP: c = second ? CH_UP_K : CH_UP_O;
      MSG_OK_LO: c = second ? CH_LO_K : CH_LO_O;
      MSG_UC:    c = second ? CH_UP_C : CH_UP_U;
      MSG_PE:    c = second ? CH_UP_E : CH_UP_P;
      MSG_FE:    c = second ? CH_UP_E : CH_UP_F;
      MSG_OE:    c = second ? CH_UP_E : CH_UP_O;
      default:   c = CH_IDLE;
    endcase
    return c;
  endfunction

  assign tx_char = idx_reg[1] ? (idx_reg[0] ? CH_LF : CH_CR) : head_char(msg_reg, idx_reg[0]);

  wire last_done = tx_done && (idx_reg == LAST_CH);
  // A frame landing with the last stop bit is answered by OE at once
  wire ovr_now   = ovr_reg | (active_reg & rx_fin_reg);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      active_reg <= 1'b0;
      ovr_reg    <= 1'b0;
      launch_reg <= 1'b0;
      msg_reg    <= MSG_UC;
      idx_reg    <= '0;
    end else begin
      launch_reg <= 1'b0;
      if (!active_reg && rx_fin_reg) begin
        active_reg <= 1'b1;
        msg_reg    <= rx_msg;
        idx_reg    <= '0;
        launch_reg <= 1'b1;
      end else if (tx_done) begin
        launch_reg <= 1'b1;
        idx_reg    <= idx_reg + 1'b1;
        if (idx_reg == LAST_CH) begin
          if (ovr_now) begin
            msg_reg <= MSG_OE;
          end else begin
            active_reg <= 1'b0;
            launch_reg <= 1'b0;
          end
        end
      end
      // Overrun at the last stop is consumed now, else a stale flag outlives busy
      if (active_reg && rx_fin_reg && !last_done) ovr_reg <= 1'b1;
      else if (last_done) ovr_reg <= 1'b0;
    end
  end

  // Transmitter
  ucr_frame_t       tx_st_reg;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic [2:0]       tx_bit_reg;
  logic [7:0]       tx_sh_reg;
  logic             tx_par_reg;
  logic             tx_line_reg;
  logic             tx_done_reg;
  wire              tx_tick = (tx_cnt_reg == '0);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_reg   <= FR_IDLE;
      tx_cnt_reg  <= '0;
      tx_bit_reg  <= '0;
      tx_sh_reg   <= '0;
      tx_par_reg  <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_done_reg <= 1'b0;
    end else begin
      tx_done_reg <= 1'b0;
      tx_cnt_reg  <= tx_tick ? BIT_LD : tx_cnt_reg - 1'b1;
      case (tx_st_reg)
        FR_IDLE: begin
          tx_line_reg <= 1'b1;
          if (launch_reg) begin
            tx_st_reg   <= FR_START;
            tx_cnt_reg  <= BIT_LD;
            tx_line_reg <= 1'b0;
            tx_sh_reg   <= tx_char;
            tx_par_reg  <= ^tx_char;
            tx_bit_reg  <= '0;
          end
        end
        FR_START: if (tx_tick) begin
          tx_st_reg   <= FR_DATA;
          tx_line_reg <= tx_sh_reg[0];
          tx_sh_reg   <= {1'b0, tx_sh_reg[7:1]};
        end
        FR_DATA: if (tx_tick) begin
          tx_bit_reg <= tx_bit_reg + 1'b1;
          if (tx_bit_reg == LAST_BIT) begin
            tx_st_reg   <= FR_PAR;
            tx_line_reg <= tx_par_reg;
          end else begin
            tx_line_reg <= tx_sh_reg[0];
            tx_sh_reg   <= {1'b0, tx_sh_reg[7:1]};
          end
        end
        FR_PAR: if (tx_tick) begin
          tx_st_reg   <= FR_STOP;
          tx_line_reg <= 1'b1;
        end
        FR_STOP: if (tx_tick) begin
          tx_st_reg   <= FR_IDLE;
          tx_done_reg <= 1'b1;
        end
        default: tx_st_reg <= FR_IDLE;
      endcase
    end
  end

  assign tx_done          = tx_done_reg;
  assign o_serial_tx_line = tx_line_reg;
  assign o_busy           = active_reg;
  assign o_events         = '{rx_done_event:  rx_fin_reg & !rx_err,
                              tx_done_event:  tx_done_reg,
                              rx_error_event: rx_fin_reg & rx_err};

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_UP_T: assert property (rx_fin_reg && !rx_err && rx_data_reg == CH_UP_T && !active_reg
    |=> msg_reg == MSG_OK_UP ##1 tx_st_reg == FR_START && tx_sh_reg == CH_UP_O)
    else $error("Upper T answer wrong");
  AST_LO_T: assert property (rx_fin_reg && !rx_err && rx_data_reg == CH_LO_T && !active_reg
    |=> msg_reg == MSG_OK_LO) else $error("Lower t answer wrong");
  AST_OTHER: assert property (rx_fin_reg && !rx_err && rx_data_reg != CH_UP_T && rx_data_reg != CH_LO_T
    && !active_reg |=> msg_reg == MSG_UC) else $error("Other char answer wrong");
  AST_PAR_ERR: assert property (rx_fin_reg && rx_pe_reg && !rx_fe_reg && !active_reg
    |=> msg_reg == MSG_PE) else $error("Parity error answer wrong");
  AST_FRM_ERR: assert property (rx_fin_reg && rx_fe_reg && !active_reg
    |=> msg_reg == MSG_FE) else $error("Framing error answer wrong");
  AST_OVR: assert property (rx_fin_reg && active_reg
    |=> ovr_reg || (active_reg && msg_reg == MSG_OE && idx_reg == '0)) else $error("Overrun not held");
  AST_PARITY_OUT: assert property (tx_st_reg == FR_PAR |-> tx_line_reg == tx_par_reg)
    else $error("Parity bit wrong");
  AST_BIT_TIME: assert property ($rose(tx_st_reg == FR_DATA) |-> tx_cnt_reg == BIT_LD)
    else $error("Bit period wrong");
  AST_IDLE_HIGH: assert property (tx_st_reg == FR_IDLE && !$past(launch_reg) |-> o_serial_tx_line)
    else $error("Idle line not high");
  AST_EVENTS: assert property (rx_fin_reg |-> o_events.rx_done_event != o_events.rx_error_event)
    else $error("Receive events not exclusive");
  AST_RETURN_IDLE: assert property (last_done && !ovr_reg && !rx_fin_reg |=> !active_reg)
    else $error("No return to idle");
  AST_NEXT_AFTER_DONE: assert property (launch_reg && active_reg |-> tx_st_reg == FR_IDLE)
    else $error("Character started early");

  COV_OK: cover property (rx_fin_reg && rx_msg == MSG_OK_UP ##1 active_reg);
  COV_ERR: cover property (o_events.rx_error_event);
  COV_OVR: cover property (last_done && ovr_reg);
endmodule // ucr_responder

/* verification/ucr_station.sv */
`timescale 1ns/1ns
module ucr_station #(
  parameter int BIT = 20
) (
  // Clock
  input  wire logic i_clk,
  // Serial link, seen from the far side
  input  wire logic i_tx_line,
  output logic      o_rx_line
);
  logic [7:0] got_q [$];
  int         bad = 0;

  initial o_rx_line = 1'b1;

  // Stop bit cut short on a framing fault so the receiver's brief re-arm on the low line is dropped as a glitch
  task automatic send(input logic [7:0] d, input bit par_bad, input bit stop_bad);
    logic [10:0] f;
    f = {~stop_bad, (^d) ^ par_bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge i_clk) o_rx_line = f[i];
      if (i == 10 && stop_bad) begin
        repeat (BIT * 3 / 5) @(negedge i_clk);
        o_rx_line = 1'b1;
      end
      repeat (BIT - 1) @(negedge i_clk);
    end
  endtask

  // Mid-bit sampling at the nominal rate
  initial begin
    logic [10:0] r;
    forever begin
      @(negedge i_tx_line);
      repeat (BIT / 2) @(posedge i_clk);
      for (int i = 0; i < 11; i++) begin
        r[i] = i_tx_line;
        if (i < 10) repeat (BIT) @(posedge i_clk);
      end
      if (r[0] !== 1'b0 || r[10] !== 1'b1 || (^r[9:1]) !== 1'b0) bad++;
      got_q.push_back(r[8:1]);
    end
  end
endmodule // ucr_station

/* verification/tb.sv */
`timescale 1ns/1ns
`define UCR_CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  import ucr_pkg::*;
  localparam int BIT = 20;

  logic       i_sys_clk;
  logic       i_rst;
  logic       rx_line;
  logic       tx_line;
  ucr_event_t ev;
  logic       busy;
  int         err_count = 0;
  int         compares  = 0;
  int         n_rxd = 0;
  int         n_txd = 0;
  int         n_rxe = 0;

  // Slow clock parameter keeps a bit at 20 cycles
  ucr_responder #(.P_CLK_HZ(192000), .P_BAUD(9600)) DUT (
    .i_sys_clk        (i_sys_clk),
    .i_rst            (i_rst),
    .i_serial_rx_line (rx_line),
    .o_serial_tx_line (tx_line),
    .o_events         (ev),
    .o_busy           (busy)
  );

  ucr_station #(.BIT(BIT)) u_station (
    .i_clk     (i_sys_clk),
    .i_tx_line (tx_line),
    .o_rx_line (rx_line)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Pulses counted mid-cycle, away from the edge that launches them
  always @(negedge i_sys_clk) begin
    if (i_rst === 1'b0) begin
      if (ev.rx_done_event === 1'b1) n_rxd++;
      if (ev.tx_done_event === 1'b1) n_txd++;
      if (ev.rx_error_event === 1'b1) n_rxe++;
    end
  end

  task automatic check_reply(input string nm, input logic [63:0] exp, input int n);
    int k;
    k = 0;
    while (u_station.got_q.size() < n && k < 8000) begin
      @(posedge i_sys_clk);
      k++;
    end
    repeat (BIT) @(negedge i_sys_clk);
    `UCR_CHK("reply count", n, u_station.got_q.size())
    `UCR_CHK("busy", 1'b0, busy)
    `UCR_CHK("tx idle", 1'b1, tx_line)
    `UCR_CHK("frame faults", 0, u_station.bad)
    for (int i = 0; i < n && u_station.got_q.size() > 0; i++) begin
      `UCR_CHK(nm, exp[8*(n-1-i) +: 8], u_station.got_q.pop_front())
    end
  endtask

  task automatic one_char(input string nm, input logic [7:0] d, input bit pb, input bit sb, input logic [31:0] exp);
    int rx0;
    int re0;
    int tx0;
    rx0 = n_rxd;
    re0 = n_rxe;
    tx0 = n_txd;
    u_station.send(d, pb, sb);
    `UCR_CHK("busy during reply", 1'b1, busy)
    check_reply(nm, {32'h0000_0000, exp}, 4);
    `UCR_CHK("rx done count", rx0 + ((pb | sb) ? 0 : 1), n_rxd)
    `UCR_CHK("rx error count", re0 + ((pb | sb) ? 1 : 0), n_rxe)
    `UCR_CHK("tx done count", tx0 + 4, n_txd)
  endtask

  task automatic test_upper();
    one_char("upper", CH_UP_T, 0, 0, {CH_UP_O, CH_UP_K, CH_CR, CH_LF});
  endtask

  task automatic test_lower();
    one_char("lower", CH_LO_T, 0, 0, {CH_LO_O, CH_LO_K, CH_CR, CH_LF});
  endtask

  task automatic test_other();
    logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'h53, 8'h75};
    foreach (codes[i]) one_char("other", codes[i], 0, 0, {CH_UP_U, CH_UP_C, CH_CR, CH_LF});
  endtask

  task automatic test_errors();
    one_char("parity", 8'h41, 1, 0, {CH_UP_P, CH_UP_E, CH_CR, CH_LF});
    one_char("framing", 8'h41, 0, 1, {CH_UP_F, CH_UP_E, CH_CR, CH_LF});
    one_char("both", 8'h54, 1, 1, {CH_UP_F, CH_UP_E, CH_CR, CH_LF});
  endtask

  // Second frame lands while the first answer is still going out
  task automatic test_overrun();
    int tx0;
    tx0 = n_txd;
    u_station.send(CH_UP_T, 0, 0);
    repeat (3 * BIT) @(negedge i_sys_clk);
    u_station.send(8'h61, 0, 0);
    check_reply("overrun", {CH_UP_O, CH_UP_K, CH_CR, CH_LF, CH_UP_O, CH_UP_E, CH_CR, CH_LF}, 8);
    `UCR_CHK("tx done count", tx0 + 8, n_txd)
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst = 1'b0;
    repeat (2 * BIT) @(negedge i_sys_clk);
    test_upper();
    test_lower();
    test_other();
    test_errors();
    test_overrun();
    test_upper();
    tally_and_finish();
  end

  // Twelve replies of about 1000 cycles each, with margin
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    err_count++;
    tally_and_finish();
  end
endmodule // tb
